// *** verilog/dwd_defs.svh ***
// constants of the display word demand channel
`ifndef DWD_DEFS_SVH
`define DWD_DEFS_SVH
`define DWD_WORD_BITS 56
`define DWD_BLK_LAST 4'hf
`define DWD_STORE_BLKS 10'h3e8
`define DWD_DEST_W 4
`define DWD_EOM_CODE 6'h0f
`define DWD_EOM_HI 54
`define DWD_EOM_LO 49
`define DWD_LINK_NS 80
`define DWD_LOAD_NS 5600000
`define DWD_ACCESS_NS 300000
`define DWD_SLOT_NS 5600000
`define DWD_RATE_KBPS 356
`define DWD_NS_PER_MS 1000000
`define DWD_LAST_PULSE 6'h37
`endif

// *** verilog/dwd_pkg.sv ***
// types of the display word demand channel
`default_nettype none
`include "dwd_defs.svh"
package dwd_pkg;
	typedef struct packed {
		logic [`DWD_DEST_W-1:0] dest;
		logic [9:0] blocks;
	} dwd_fill_cmd_s;
	typedef struct packed {
		logic first;
		logic [`DWD_WORD_BITS-1:0] data;
	} dwd_word_s;
	typedef enum logic [1:0] {
		L_IDLE = 2'h0, L_WAIT = 2'h1, L_SEND = 2'h3, L_ACK = 2'h2
	} dwd_link_e;
endpackage
`default_nettype wire

// *** verilog/dwd_channel.sv ***
// one display output channel: store, circulating register, serial link
`timescale 1ns/1ns
`default_nettype none
`include "dwd_defs.svh"
module dwd_channel #(
	parameter int SLOT_CYC = `DWD_SLOT_NS / `DWD_LINK_NS,
	parameter int LOAD_CYC = (`DWD_LOAD_NS + `DWD_ACCESS_NS)
		/ `DWD_LINK_NS,
	parameter logic [`DWD_DEST_W-1:0] CHAN_ID = 4'h0
) (
	// clocks and reset
	input wire logic clk_sys,
	input wire logic clk_link,
	input wire logic reset_n,
	// processor fill side
	input wire logic fill_cmd_valid,
	input wire dwd_pkg::dwd_fill_cmd_s fill_cmd,
	input wire logic fill_word_valid,
	input wire logic [`DWD_WORD_BITS-1:0] fill_word,
	output logic fill_ready,
	input wire logic fetch_grant,
	// events and status
	output logic irq_full,
	output logic irq_depleted,
	output logic irq_msg_end,
	output logic stat_sending,
	output logic stat_depleted,
	output logic stat_aborted,
	output logic stat_msg_ok,
	output logic stat_display_present,
	// console link
	input wire logic word_request,
	output logic word_strobe,
	output logic serial_clock,
	output logic serial_data
);
	import dwd_pkg::*;
	// ----------------------------------------------------------
	// link timing
	// ----------------------------------------------------------
	localparam logic [16:0] SLOT = 17'(SLOT_CYC);
	localparam logic [16:0] LOADW = 17'(LOAD_CYC);
	// half bit period in link cycles, rounded down
	localparam logic [4:0] HALF = 5'(`DWD_NS_PER_MS
		/ (`DWD_RATE_KBPS * 2 * `DWD_LINK_NS));
	// ----------------------------------------------------------
	// system domain state
	// ----------------------------------------------------------
	logic [`DWD_WORD_BITS-1:0] store [0:16383]; // shared store
	logic [`DWD_WORD_BITS-1:0] circ [0:31]; // two blocks
	logic [9:0] fptr_r, dptr_r, gptr_r; // fill, drain, fetch
	logic [9:0] left_r, cnt_r, unf_r; // to fill, held, unfetched
	logic [3:0] fw_r, gw_r, widx_r; // word indices
	logic fetch_r, ghalf_r, cur_r; // fetch in progress
	logic [1:0] cv_r; // circulating halves valid
	logic active_r, busy_r, first_r, eom_r;
	dwd_word_s word_r; // word offered to link
	logic rtog_r, dseen_r; // crossing toggles
	logic [1:0] req_s, dt_s; // synchronisers
	logic fill_ready_r, irq_full_r, irq_dep_r, irq_end_r;
	logic dep_r, abt_r, ok_r, pres_r;
	logic done_tg_l, ok_l; // link answers
	// ----------------------------------------------------------
	// system decode
	// ----------------------------------------------------------
	function automatic logic [9:0] nx(input logic [9:0] p);
		nx = (p == `DWD_STORE_BLKS - 10'h001) ? 10'h000
			: p + 10'h001;
	endfunction
	wire filling = (left_r != 10'h000);
	wire cmd_hit = fill_cmd_valid && !filling
		&& fill_cmd.dest == CHAN_ID && fill_cmd.blocks != 10'h000;
	wire acc = fill_word_valid && fill_ready_r;
	wire blk_in = acc && fw_r == `DWD_BLK_LAST;
	wire fetch_go = !fetch_r && unf_r != 10'h000 && !filling
		&& fetch_grant && cv_r != 2'h3;
	wire fetch_end = fetch_r && gw_r == `DWD_BLK_LAST;
	wire done_in = dt_s[1] != dseen_r;
	wire wok = done_in && ok_l;
	wire wabt = done_in && !ok_l;
	wire blk_out = wok && widx_r == `DWD_BLK_LAST;
	wire offer = active_r && !busy_r && cv_r[cur_r];
	wire deplete = active_r && !busy_r && cnt_r == 10'h000
		&& !filling && !cmd_hit;
	wire is_eom = circ[{cur_r, widx_r}][`DWD_EOM_HI:`DWD_EOM_LO]
		== `DWD_EOM_CODE;
	wire [9:0] cnt_nxt = cnt_r + {9'h000, blk_in}
		- {9'h000, blk_out};
	// ----------------------------------------------------------
	// store filling
	// ----------------------------------------------------------
	// processor words land at fill pointer
	always_ff @(posedge clk_sys) begin
		if (acc) begin
			store[{fptr_r, fw_r}] <= fill_word;
		end
	end
	// fill counters, ready only with request and room
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			left_r <= 10'h000;
			fptr_r <= 10'h000;
			fw_r <= 4'h0;
			fill_ready_r <= 1'b0;
			irq_full_r <= 1'b0;
		end else begin
			if (cmd_hit) left_r <= fill_cmd.blocks;
			else if (blk_in) left_r <= left_r - 10'h001;
			if (acc) fw_r <= fw_r + 4'h1;
			if (blk_in) fptr_r <= nx(fptr_r);
			fill_ready_r <= (filling || cmd_hit) && req_s[1]
				&& cnt_nxt != `DWD_STORE_BLKS && !blk_in;
			irq_full_r <= blk_in && cnt_nxt == `DWD_STORE_BLKS;
		end
	end
	// ----------------------------------------------------------
	// circulating register fetch
	// ----------------------------------------------------------
	// copy one block into the empty half
	always_ff @(posedge clk_sys) begin
		if (fetch_r) begin
			circ[{ghalf_r, gw_r}] <= store[{gptr_r, gw_r}];
		end
	end
	// ----------------------------------------------------------
	// word offer and recycling
	// ----------------------------------------------------------
	// halves alternate; sent block drained and freed
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{cnt_r, unf_r, dptr_r, gptr_r} <= 40'h0;
			{gw_r, widx_r} <= 8'h00;
			{fetch_r, ghalf_r, cur_r, cv_r} <= 5'h00;
			{active_r, busy_r, first_r, eom_r} <= 4'h0;
			{rtog_r, dseen_r, req_s, dt_s} <= 6'h00;
			word_r <= '0;
			{irq_dep_r, irq_end_r, dep_r, abt_r} <= 4'h0;
			{ok_r, pres_r} <= 2'h0;
		end else begin
			req_s <= {req_s[0], word_request};
			dt_s <= {dt_s[0], done_tg_l};
			pres_r <= req_s[1];
			cnt_r <= cnt_nxt;
			unf_r <= unf_r + {9'h000, blk_in}
				- {9'h000, fetch_end};
			irq_dep_r <= 1'b0;
			irq_end_r <= 1'b0;
			if (fetch_go) begin
				fetch_r <= 1'b1;
				ghalf_r <= cv_r[cur_r] ? !cur_r : cur_r;
				gw_r <= 4'h0;
			end else if (fetch_r) begin
				gw_r <= gw_r + 4'h1;
			end
			if (fetch_end) begin
				fetch_r <= 1'b0;
				gptr_r <= nx(gptr_r);
			end
			if (cmd_hit) begin
				active_r <= 1'b1;
				dep_r <= 1'b0;
				if (!active_r) first_r <= 1'b1;
			end
			if (offer) begin
				word_r <= '{first_r, circ[{cur_r, widx_r}]};
				rtog_r <= !rtog_r;
				busy_r <= 1'b1;
				eom_r <= is_eom;
			end
			if (done_in) begin
				dseen_r <= dt_s[1];
				busy_r <= 1'b0;
				first_r <= 1'b0;
			end
			if (wok) widx_r <= widx_r + 4'h1;
			if (blk_out) begin
				cur_r <= !cur_r;
				dptr_r <= nx(dptr_r);
			end
			cv_r <= (cv_r & ~(blk_out ? 2'h1 << cur_r : 2'h0))
				| (fetch_end ? 2'h1 << ghalf_r : 2'h0);
			if (wabt) begin
				// abort drops every held block
				{active_r, fetch_r, cv_r} <= 4'h0;
				{cnt_r, unf_r} <= 20'h0;
				dptr_r <= fptr_r;
				gptr_r <= fptr_r;
				widx_r <= 4'h0;
				abt_r <= 1'b1;
				ok_r <= 1'b0;
				irq_end_r <= 1'b1;
			end else if (deplete) begin
				active_r <= 1'b0;
				dep_r <= 1'b1;
				abt_r <= 1'b0;
				irq_dep_r <= 1'b1;
				irq_end_r <= eom_r;
				ok_r <= eom_r;
				first_r <= eom_r;
			end
		end
	end
	assign fill_ready = fill_ready_r;
	assign irq_full = irq_full_r;
	assign irq_depleted = irq_dep_r;
	assign irq_msg_end = irq_end_r;
	assign stat_sending = active_r;
	assign stat_depleted = dep_r;
	assign stat_aborted = abt_r;
	assign stat_msg_ok = ok_r;
	assign stat_display_present = pres_r;
	// ----------------------------------------------------------
	// link domain
	// ----------------------------------------------------------
	dwd_link_e st_r, st_nxt;
	logic [1:0] req_l, rt_l, ps_l; // synchronisers
	logic seen_r, acked_r;
	logic [16:0] cnt_l, lim_l; // slot timer
	logic [4:0] hc_r; // half bit counter
	logic [5:0] bits_r; // pulses sent
	logic [`DWD_WORD_BITS-1:0] sreg_r;
	logic strobe_r, sclk_r, data_r;
	// top character first, each character least bit first
	function automatic logic [55:0] order(input logic [55:0] w);
		for (int i = 0; i < 8; i++) begin
			order[i*7 +: 7] = w[(7-i)*7 +: 7];
		end
	endfunction
	wire tick = cnt_l == lim_l - 17'h0_0001;
	wire new_word = rt_l[1] != seen_r;
	wire half = hc_r == HALF - 5'h01;
	wire fall = half && sclk_r;
	wire last = fall && bits_r == `DWD_LAST_PULSE;
	wire can_go = tick && new_word && req_l[1]
		&& !ps_l[1];
	wire fail_first = tick && new_word && word_r.first
		&& !req_l[1];
	// no resend while the store is being filled
	wire resend = st_r == L_ACK && tick && req_l[1]
		&& !acked_r && !ps_l[1];
	wire ack_seen = st_r == L_ACK && !req_l[1];
	wire start = (st_r == L_WAIT && can_go) || resend;
	wire [55:0] ord = order(word_r.data);
	// next link state
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			L_IDLE: if (new_word) st_nxt = L_WAIT;
			L_WAIT: begin
				if (can_go) st_nxt = L_SEND;
				else if (fail_first || tick) st_nxt = L_IDLE;
			end
			L_SEND: if (last) st_nxt = L_ACK;
			L_ACK: begin
				if (ack_seen) st_nxt = L_WAIT;
				else if (resend) st_nxt = L_SEND;
			end
			default: st_nxt = L_IDLE;
		endcase
	end
	// slot timer restarts at word end
	always_ff @(posedge clk_link or negedge reset_n) begin
		if (!reset_n) begin
			cnt_l <= 17'h0_0000;
			lim_l <= SLOT;
		end else if (st_r == L_IDLE) begin
			cnt_l <= 17'h0_0000;
			lim_l <= word_r.first ? LOADW : SLOT;
		end else if (last || tick) begin
			cnt_l <= 17'h0_0000;
			lim_l <= SLOT;
		end else begin
			cnt_l <= cnt_l + 17'h0_0001;
		end
	end
	// word shift and handshake
	always_ff @(posedge clk_link or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= L_IDLE;
			{req_l, rt_l, ps_l} <= 6'h00;
			{seen_r, acked_r, done_tg_l, ok_l} <= 4'h0;
			{hc_r, bits_r} <= 11'h000;
			sreg_r <= '0;
			{strobe_r, sclk_r, data_r} <= 3'h0;
		end else begin
			st_r <= st_nxt;
			req_l <= {req_l[0], word_request};
			rt_l <= {rt_l[0], rtog_r};
			ps_l <= {ps_l[0], filling};
			hc_r <= (start || half) ? 5'h00 : hc_r + 5'h01;
			if (start) begin
				seen_r <= rt_l[1];
				sreg_r <= ord;
				{strobe_r, sclk_r, data_r} <= {2'h2, ord[0]};
				bits_r <= 6'h00;
				acked_r <= 1'b0;
			end else if (st_r == L_SEND && half) begin
				sclk_r <= !sclk_r;
				if (fall) begin
					bits_r <= bits_r + 6'h01;
					sreg_r <= sreg_r >> 1;
					data_r <= last ? 1'b0 : sreg_r[1];
					strobe_r <= !last;
				end
			end
			if (ack_seen && !acked_r) begin
				acked_r <= 1'b1;
				done_tg_l <= !done_tg_l;
				ok_l <= 1'b1;
			end else if (st_r == L_WAIT && fail_first) begin
				seen_r <= rt_l[1];
				done_tg_l <= !done_tg_l;
				ok_l <= 1'b0;
			end
		end
	end
	assign word_strobe = strobe_r;
	assign serial_clock = sclk_r;
	assign serial_data = data_r;
	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	a_clock_in_word: assert property (@(posedge clk_link)
		disable iff (!reset_n) !strobe_r |-> !sclk_r)
		else $error("serial clock outside word");
	a_pulse_count: assert property (@(posedge clk_link)
		disable iff (!reset_n) $fell(strobe_r) |->
		bits_r == 6'h38)
		else $error("word not 56 pulses");
	a_strobe_cause: assert property (@(posedge clk_link)
		disable iff (!reset_n) $rose(strobe_r) |->
		$past(req_l[1]) && !$past(ps_l[1]))
		else $error("strobe without request");
	a_slot_edge: assert property (@(posedge clk_link)
		disable iff (!reset_n) $rose(strobe_r) |-> $past(tick))
		else $error("word off slot");
	a_fill_gate: assert property (@(posedge clk_sys)
		disable iff (!reset_n) fill_ready_r |-> $past(req_s[1]))
		else $error("fill without request");
	a_no_overtake: assert property (@(posedge clk_sys)
		disable iff (!reset_n) cnt_r <= `DWD_STORE_BLKS)
		else $error("fill passed drain");
	a_fill_step: assert property (@(posedge clk_sys)
		disable iff (!reset_n) blk_in |=> fptr_r == nx($past(fptr_r)))
		else $error("fill pointer step");
	a_depl_stop: assert property (@(posedge clk_sys)
		disable iff (!reset_n) irq_dep_r |->
		!active_r && cnt_r == 10'h000)
		else $error("depleted while sending");
endmodule
`default_nettype wire

// *** testbench/dwd_console_model.sv ***
// console model: takes serial words and acknowledges on the request line
`timescale 1ns/1ns
`default_nettype none
module dwd_console_model (
	// clock and reset
	input wire logic clk_link,
	input wire logic reset_n,
	// bench control: console powered and willing
	input wire logic allow,
	// link
	input wire logic word_strobe,
	input wire logic serial_clock,
	input wire logic serial_data,
	output logic word_request,
	// what was received
	output logic [55:0] rx_word,
	output int rx_pulses,
	output int rx_gap,
	output int rx_count
);
	logic sclk_q; // last serial clock
	logic strobe_q; // last strobe
	logic eom_hold; // end code seen
	logic [55:0] sh; // word being assembled
	int idx; // pulse count in word
	int gap_cnt; // link cycles strobe low
	int ack_cnt; // acknowledge timer
	// chars 7..0, each least bit first
	wire integer bit_pos = (7 - idx / 7) * 7 + idx % 7;
	// low from 20 to 150 cycles after strobe fall: over 10 us
	assign word_request = allow && !eom_hold
		&& !(ack_cnt >= 20);
	// ----------------------------------------
	// receiver and acknowledge
	// ----------------------------------------
	always_ff @(posedge clk_link or negedge reset_n) begin
		if (!reset_n) begin
			sclk_q <= 0;
			strobe_q <= 0;
			eom_hold <= 0;
			sh <= '0;
			idx <= 0;
			gap_cnt <= 0;
			ack_cnt <= 0;
			rx_word <= '0;
			rx_pulses <= 0;
			rx_gap <= 0;
			rx_count <= 0;
		end else begin
			sclk_q <= serial_clock;
			strobe_q <= word_strobe;
			gap_cnt <= word_strobe ? 0 : gap_cnt + 1;
			// new message only after console is reset
			if (!allow)
				eom_hold <= 0;
			if (word_strobe && !strobe_q) begin
				rx_gap <= gap_cnt;
				idx <= 0;
			end else if (serial_clock && !sclk_q) begin
				sh[bit_pos] <= serial_data;
				idx <= idx + 1;
			end
			if (!word_strobe && strobe_q) begin
				rx_word <= sh;
				rx_pulses <= idx;
				rx_count <= rx_count + 1;
				ack_cnt <= 1;
				if (sh[54:49] == 6'h0f)
					eom_hold <= 1;
			end else if (ack_cnt != 0) begin
				ack_cnt <= (ack_cnt == 150) ? 0 : ack_cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire

// *** testbench/display_word_demand_channel_test.sv ***
// bench for the display word demand channel
`timescale 1ns/1ns
`default_nettype none
module display_word_demand_channel_test;
	import dwd_pkg::*;
	logic clk_sys = 0, clk_link = 0, reset_n = 0;
	logic fill_cmd_valid = 0, fill_word_valid = 0, fetch_grant = 1;
	dwd_fill_cmd_s fill_cmd = '0;
	logic [55:0] fill_word = '0;
	logic allow = 1;
	logic fill_ready, irq_full, irq_depleted, irq_msg_end, stat_sending;
	logic stat_depleted, stat_aborted, stat_msg_ok, stat_display_present;
	logic word_request, word_strobe, serial_clock, serial_data;
	logic [55:0] rx_word;
	int rx_pulses, rx_gap, rx_count;
	int fail_count = 0, samples_checked = 0, cyc = 0, n_dep = 0, n_end = 0;
	int n_full = 0;
	always #4 clk_sys = ~clk_sys;
	always #40 clk_link = ~clk_link;
	dwd_channel #(.SLOT_CYC(200), .LOAD_CYC(300), .CHAN_ID(4'h0))
		dwd_channel_i (
		.clk_sys(clk_sys), .clk_link(clk_link), .reset_n(reset_n),
		.fill_cmd_valid(fill_cmd_valid), .fill_cmd(fill_cmd),
		.fill_word_valid(fill_word_valid), .fill_word(fill_word),
		.fill_ready(fill_ready), .fetch_grant(fetch_grant),
		.irq_full(irq_full), .irq_depleted(irq_depleted),
		.irq_msg_end(irq_msg_end), .stat_sending(stat_sending),
		.stat_depleted(stat_depleted), .stat_aborted(stat_aborted),
		.stat_msg_ok(stat_msg_ok),
		.stat_display_present(stat_display_present),
		.word_request(word_request), .word_strobe(word_strobe),
		.serial_clock(serial_clock), .serial_data(serial_data));
	dwd_console_model dwd_console_model_i (
		.clk_link(clk_link), .reset_n(reset_n), .allow(allow),
		.word_strobe(word_strobe), .serial_clock(serial_clock),
		.serial_data(serial_data), .word_request(word_request),
		.rx_word(rx_word), .rx_pulses(rx_pulses), .rx_gap(rx_gap),
		.rx_count(rx_count));
	// interrupt pulse counters
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (irq_depleted === 1'b1) n_dep <= n_dep + 1;
		if (irq_msg_end === 1'b1) n_end <= n_end + 1;
		if (irq_full === 1'b1) n_full <= n_full + 1;
		// one block of 16 words takes about 340000 cycles
		if (cyc == 450000) begin
			fail_count = fail_count + 1;
			give_verdict();
		end
	end
	// word k of the block; last one carries the end code
	function automatic logic [55:0] wd(input int k);
		if (k == 15)
			return 56'h1e_0000_0000_0000;
		return {8'(k), 48'h1234_5678_9abc};
	endfunction
	task automatic check(input string what, input logic [63:0] seen, exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one command, then nw words under the ready handshake
	task automatic fill(input logic [3:0] d, input int nw);
		int t;
		@(posedge clk_sys);
		fill_cmd_valid <= 1;
		fill_cmd <= '{dest: d, blocks: 10'h001};
		@(posedge clk_sys);
		fill_cmd_valid <= 0;
		for (int i = 0; i < nw; i++) begin
			fill_word_valid <= 1;
			fill_word <= wd(i);
			t = 0;
			do begin
				@(posedge clk_sys);
				t++;
			end while (fill_ready !== 1'b1 && t < 100);
			check("fill_ready", fill_ready, 1);
		end
		fill_word_valid <= 0;
		repeat (5) @(posedge clk_sys);
	endtask
	task automatic wait_sys(ref int cnt, input int n);
		for (int t = 0; t < 40000 && cnt < n; t++)
			@(posedge clk_sys);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_link);
		@(posedge clk_sys);
		reset_n <= 1;
		repeat (20) @(posedge clk_sys);
		check("stat_display_present", stat_display_present, 1);
		// foreign destination: no words taken
		fill(4'h5, 0);
		check("fill_ready", fill_ready, 0);
		$display("test destination done");
		// one block, end code in the last word
		fill(4'h0, 16);
		for (int i = 0; i < 16; i++) begin
			for (int t = 0; t < 6000 && rx_count < i + 1; t++)
				@(posedge clk_link);
			check("rx_word", rx_word, wd(i));
			check("rx_pulses", rx_pulses, 56);
			if (i == 0)
				check("stat_sending", stat_sending, 1);
			if (i > 0)
				check("slot gap", rx_gap >= 200 && rx_gap < 400, 1);
		end
		wait_sys(n_end, 1);
		check("irq_depleted", n_dep, 1);
		check("irq_msg_end", n_end, 1);
		check("stat_msg_ok", stat_msg_ok, 1);
		check("stat_depleted", stat_depleted, 1);
		check("stat_sending", stat_sending, 0);
		check("irq_full", n_full, 0);
		$display("test message done");
		// request dropped before the first word: abort
		allow <= 0;
		repeat (50) @(posedge clk_sys);
		allow <= 1;
		fetch_grant <= 0;
		repeat (50) @(posedge clk_sys);
		fill(4'h0, 16);
		allow <= 0;
		// no grant: block stays in the store, no word, no abort
		repeat (5000) @(posedge clk_sys);
		check("irq_msg_end", n_end, 1);
		check("stat_sending", stat_sending, 1);
		fetch_grant <= 1;
		wait_sys(n_end, 2);
		check("irq_msg_end", n_end, 2);
		check("stat_aborted", stat_aborted, 1);
		check("stat_depleted", stat_depleted, 0);
		check("stat_msg_ok", stat_msg_ok, 0);
		check("rx_count", rx_count, 16);
		check("stat_display_present", stat_display_present, 0);
		$display("test abort done");
		give_verdict();
	end
endmodule
`default_nettype wire
